// [hw/txc_params.svh]
// constants for the transmit parallel character capture port
`ifndef TXC_PARAMS_SVH
`define TXC_PARAMS_SVH

// ============================================================
// widths
`define TXC_CHAR_W      12
`define TXC_LOW_W       8
`define TXC_SHARED_W    2
`define TXC_CMD_LOW_W   2

// ============================================================
// field positions inside the captured character
`define TXC_LOW_LSB     0
`define TXC_LOW_MSB     7
`define TXC_SHARED_LSB  8
`define TXC_SHARED_MSB  9
`define TXC_TOP_LSB     10
`define TXC_TOP_MSB     11
`define TXC_CMD_LSB     0
`define TXC_CMD_MSB     1
`define TXC_CMD_HI_LSB  2
`define TXC_CMD_HI_MSB  3

// ============================================================
// reset values
`define TXC_CHAR_RST    12'h000

`endif

// [hw/txc_pkg.sv]
// types shared by the transmit parallel character capture port
package txc_pkg;

    // ============================================================
    // character and capture state types
    typedef logic [11:0] txc_char_t;

    typedef enum logic [1:0] {
        TXC_ST_IDLE = 2'b01,
        TXC_ST_PEND = 2'b10
    } txc_state_t;

endpackage

// [hw/txc_char_map.sv]
// maps the parallel transmit inputs onto one captured character
`timescale 1ns/1ns
`default_nettype none
`include "txc_params.svh"

module txc_char_map (
    input  wire logic                        char_width_select,
    input  wire logic                        encoder_bypass_n,
    input  wire logic                        tx_cmd_data_select,
    input  wire logic [`TXC_LOW_W-1:0]       tx_char_low_in,
    input  wire logic [`TXC_SHARED_W-1:0]    tx_shared_upper_in,
    input  wire logic [`TXC_CMD_LOW_W-1:0]   tx_command_low_in,
    output var  txc_pkg::txc_char_t          map_char,
    output var  logic                        map_is_cmd,
    output var  logic                        map_precoded
);

    // ============================================================
    // per-mode candidates
    wire logic                  bypass      = !encoder_bypass_n;
    wire logic                  width8      = char_width_select;
    // shared pins pair 9<->cmd2, 8<->cmd3
    wire logic [3:0]            cmd4        = {tx_shared_upper_in[0], tx_shared_upper_in[1],
                                               tx_command_low_in};
    wire txc_pkg::txc_char_t    byp8_char   = {2'h0, tx_shared_upper_in, tx_char_low_in};
    wire txc_pkg::txc_char_t    byp10_char  = {tx_command_low_in, tx_shared_upper_in,
                                               tx_char_low_in};
    wire txc_pkg::txc_char_t    cmd8_char   = {8'h00, cmd4};
    wire txc_pkg::txc_char_t    dat8_char   = {4'h0, tx_char_low_in};
    wire txc_pkg::txc_char_t    cmd10_char  = {10'h000, tx_command_low_in};
    wire txc_pkg::txc_char_t    dat10_char  = {2'h0, tx_shared_upper_in, tx_char_low_in};

    // ============================================================
    // selection
    assign map_char = bypass ? (width8 ? byp8_char : byp10_char)
                    : width8 ? (tx_cmd_data_select ? cmd8_char : dat8_char)
                    : (tx_cmd_data_select ? cmd10_char : dat10_char);
    assign map_is_cmd   = !bypass && tx_cmd_data_select;
    assign map_precoded = bypass;

endmodule
`default_nettype wire

// [hw/txc_capture.sv]
// transmit parallel character capture port, top level
// ============================================================
// Summary of operation
// - inputs are taken on rising edges of the transmit fifo clock, or of the reference clock when the fifo is bypassed.
// - selected with selector low, low eight inputs form a data value.
// - fifo enabled samples on fifo clock; bypassed samples on reference clock.
// - encoder bypassed: low eight inputs are the low pre-encoded bits.
// - encoder bypassed: shared upper inputs are pre-encoded bits nine and ten.
// - 8-bit encoded: shared inputs are command bits 2 and 3 when selector high.
// - 10-bit encoded: shared inputs are data bits 9 and 8 when selector low.
// - 8-bit bypassed: the dedicated low command inputs are ignored.
// - 10-bit bypassed: low command inputs are pre-encoded bits eleven and twelve.
// - 8-bit encoded: selector picks 4-bit command or 8-bit data.
// - 10-bit encoded: selector picks 2-bit command or 10-bit data.
// - encoder bypassed: selector ignored, character passes as pre-encoded.
// - selected only if write enable follows a sample with chip select low.
// - external fifo mode flips write enable polarity and delays capture one sample.
`timescale 1ns/1ns
`default_nettype none
`include "txc_params.svh"

module txc_capture (
    input  wire logic                        clk,
    input  wire logic                        rstn,
    input  wire logic                        ce,
    input  wire logic                        tx_fifo_clock,
    input  wire logic                        ref_clock_in,
    input  wire logic                        fifo_bypass_n,
    input  wire logic                        external_fifo_mode,
    input  wire logic                        tx_chip_select_n,
    input  wire logic                        tx_write_enable,
    input  wire logic                        char_width_select,
    input  wire logic                        encoder_bypass_n,
    input  wire logic                        tx_cmd_data_select,
    input  wire logic [`TXC_LOW_W-1:0]       tx_char_low_in,
    input  wire logic [`TXC_SHARED_W-1:0]    tx_shared_upper_in,
    input  wire logic [`TXC_CMD_LOW_W-1:0]   tx_command_low_in,
    output var  txc_pkg::txc_char_t          tx_char_q,
    output var  logic                        tx_char_is_cmd_q,
    output var  logic                        tx_char_precoded_q,
    output var  logic                        tx_write_strobe_q
);

    // ============================================================
    // sample edge detection
    logic                   fifo_clk_prev_q;
    logic                   ref_clk_prev_q;
    logic                   cs_seen_q;
    txc_pkg::txc_state_t    state_q;
    txc_pkg::txc_state_t    state_d;

    wire logic fifo_edge   = tx_fifo_clock && !fifo_clk_prev_q;
    wire logic ref_edge    = ref_clock_in && !ref_clk_prev_q;
    wire logic sample_edge = fifo_bypass_n ? fifo_edge : ref_edge;

    // ============================================================
    // selection and write decision
    wire logic en_active = external_fifo_mode ? tx_write_enable : !tx_write_enable;
    wire logic selected  = sample_edge && cs_seen_q && en_active;
    wire logic pending   = state_q == txc_pkg::TXC_ST_PEND;
    wire logic write_now = sample_edge && (external_fifo_mode ? pending : selected);

    always_comb
    begin
        state_d = state_q;
        unique case (state_q)
            txc_pkg::TXC_ST_IDLE:
            begin
                if (sample_edge && external_fifo_mode && selected)
                    state_d = txc_pkg::TXC_ST_PEND;
            end
            txc_pkg::TXC_ST_PEND:
            begin
                if (sample_edge && !(external_fifo_mode && selected))
                    state_d = txc_pkg::TXC_ST_IDLE;
            end
            default:
            begin
                state_d = txc_pkg::TXC_ST_IDLE;
            end
        endcase
    end

    // ============================================================
    // character mapping
    txc_pkg::txc_char_t map_char;
    logic               map_is_cmd;
    logic               map_precoded;

    txc_char_map u_map (
        .char_width_select  (char_width_select),
        .encoder_bypass_n   (encoder_bypass_n),
        .tx_cmd_data_select (tx_cmd_data_select),
        .tx_char_low_in     (tx_char_low_in),
        .tx_shared_upper_in (tx_shared_upper_in),
        .tx_command_low_in  (tx_command_low_in),
        .map_char           (map_char),
        .map_is_cmd         (map_is_cmd),
        .map_precoded       (map_precoded)
    );

    // ============================================================
    // state registers
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            fifo_clk_prev_q <= 1'b0;
            ref_clk_prev_q  <= 1'b0;
            cs_seen_q       <= 1'b0;
            state_q         <= txc_pkg::TXC_ST_IDLE;
        end
        else if (ce)
        begin
            fifo_clk_prev_q <= tx_fifo_clock;
            ref_clk_prev_q  <= ref_clock_in;
            if (sample_edge)
                cs_seen_q <= !tx_chip_select_n;
            state_q <= state_d;
        end
    end

    // ============================================================
    // captured character outputs
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            tx_char_q          <= `TXC_CHAR_RST;
            tx_char_is_cmd_q   <= 1'b0;
            tx_char_precoded_q <= 1'b0;
            tx_write_strobe_q  <= 1'b0;
        end
        else if (ce)
        begin
            tx_write_strobe_q <= write_now;
            if (write_now)
            begin
                tx_char_q          <= map_char;
                tx_char_is_cmd_q   <= map_is_cmd;
                tx_char_precoded_q <= map_precoded;
            end
        end
    end

    // ============================================================
    // assertions
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    wire logic enc_on = encoder_bypass_n;

    a_strobe_on_edge: assert property (
        $rose(tx_write_strobe_q) |-> $past(sample_edge))
        else $error("strobe without a sample edge");

    a_clock_source_sel: assert property (
        ce && fifo_bypass_n && !fifo_edge |=> !tx_write_strobe_q)
        else $error("capture off the fifo clock while fifo enabled");

    a_no_write_unsel: assert property (
        ce && !external_fifo_mode && sample_edge && !selected |=> !tx_write_strobe_q)
        else $error("write in an unselected sample");

    a_data_low_char: assert property (
        ce && write_now && enc_on && !tx_cmd_data_select
        |=> tx_char_q[7:0] == $past(tx_char_low_in) && !tx_char_is_cmd_q)
        else $error("data value not captured");

    a_bypass_low_bits: assert property (
        ce && write_now && !enc_on
        |=> tx_char_q[7:0] == $past(tx_char_low_in) && tx_char_precoded_q)
        else $error("pre-encoded low bits wrong");

    a_bypass_upper_bits: assert property (
        ce && write_now && !enc_on |=> tx_char_q[9:8] == $past(tx_shared_upper_in))
        else $error("pre-encoded bits nine and ten wrong");

    a_cmd8_upper_bits: assert property (
        ce && write_now && enc_on && char_width_select && tx_cmd_data_select
        |=> tx_char_q[3:2] == {$past(tx_shared_upper_in[0]), $past(tx_shared_upper_in[1])}
            && tx_char_q[11:4] == 8'h00)
        else $error("8-bit command upper bits wrong");

    a_data10_upper_bits: assert property (
        ce && write_now && enc_on && !char_width_select && !tx_cmd_data_select
        |=> tx_char_q[9:8] == $past(tx_shared_upper_in) && tx_char_q[11:10] == 2'h0)
        else $error("10-bit data upper bits wrong");

    a_byp8_cmd_ignored: assert property (
        ce && write_now && !enc_on && char_width_select |=> tx_char_q[11:10] == 2'h0)
        else $error("command inputs not ignored in 8-bit bypass");

    a_byp10_top_bits: assert property (
        ce && write_now && !enc_on && !char_width_select
        |=> tx_char_q[11:10] == $past(tx_command_low_in))
        else $error("bits eleven and twelve wrong");

    a_cmd10_only: assert property (
        ce && write_now && enc_on && !char_width_select && tx_cmd_data_select
        |=> tx_char_q == {10'h000, $past(tx_command_low_in)} && tx_char_is_cmd_q)
        else $error("10-bit command wrong");

    a_selector_ignored: assert property (
        ce && write_now && !enc_on |=> !tx_char_is_cmd_q)
        else $error("selector used while bypassed");

    a_cs_before_enable: assert property (
        ce && sample_edge && en_active && !cs_seen_q && !external_fifo_mode
        |=> !tx_write_strobe_q)
        else $error("selected without prior chip select");

    a_ext_next_sample: assert property (
        ce && external_fifo_mode && selected
        |=> pending && tx_write_strobe_q == $past(pending))
        else $error("external fifo capture not deferred");

    a_enc8_char_form: assert property (
        ce && write_now && enc_on && char_width_select
        |=> tx_char_q[11:8] == 4'h0 && tx_char_is_cmd_q == $past(tx_cmd_data_select)
            && (tx_char_is_cmd_q ? tx_char_q[1:0] == $past(tx_command_low_in)
                                 : tx_char_q[7:0] == $past(tx_char_low_in)))
        else $error("8-bit encoded character wrong");

    c_data_write: cover property (
        ce && write_now && enc_on && !tx_cmd_data_select);
    c_cmd_write: cover property (
        ce && write_now && enc_on && tx_cmd_data_select);
    c_bypass_write: cover property (
        ce && write_now && !enc_on && !char_width_select);
    c_ext_write: cover property (
        ce && write_now && external_fifo_mode);

endmodule
`default_nettype wire

// [bench/txc_host_model.sv]
// host side model that writes characters into the capture port
`timescale 1ns/1ns
`default_nettype none

module txc_host_model (
    input  wire logic        clk,
    output var  logic        tx_fifo_clock,
    output var  logic        ref_clock_in,
    output var  logic        tx_chip_select_n,
    output var  logic        tx_write_enable,
    output var  logic        tx_cmd_data_select,
    output var  logic [7:0]  tx_char_low_in,
    output var  logic [1:0]  tx_shared_upper_in,
    output var  logic [1:0]  tx_command_low_in
);
    // ============================================================
    // idle levels: pins float to their pull-ups, clocks stand still low
    task automatic release_pins;
        tx_chip_select_n = 1'b1;
        tx_write_enable = 1'b1;
        {tx_cmd_data_select, tx_char_low_in, tx_shared_upper_in, tx_command_low_in} = 13'h1FFF;
    endtask

    initial
    begin
        {tx_fifo_clock, ref_clock_in} = 2'b00;
        release_pins();
    end

    // ============================================================
    // one clk cycle of the chosen sampling clock
    task automatic step(input logic use_ref, input logic lvl);
        @(posedge clk);
        #1;
        if (use_ref)
            ref_clock_in = lvl;
        else
            tx_fifo_clock = lvl;
    endtask

    // ============================================================
    // a full write: select sample, enable sample, data sample in mode 1
    task automatic send(input logic mode, input logic use_ref, input logic cs_ok,
                        input logic sel, input logic [7:0] low, input logic [1:0] sh,
                        input logic [1:0] cl);
        step(use_ref, 1'b0);
        tx_chip_select_n = ~cs_ok;
        step(use_ref, 1'b1);
        step(use_ref, 1'b0);
        tx_chip_select_n = 1'b1;
        tx_write_enable = mode;
        if (!mode)
            {tx_cmd_data_select, tx_char_low_in, tx_shared_upper_in, tx_command_low_in} =
                {sel, low, sh, cl};
        step(use_ref, 1'b1);
        step(use_ref, 1'b0);
        if (mode)
        begin
            tx_write_enable = 1'b0;
            {tx_cmd_data_select, tx_char_low_in, tx_shared_upper_in, tx_command_low_in} =
                {sel, low, sh, cl};
            step(use_ref, 1'b1);
            step(use_ref, 1'b0);
        end
        release_pins();
    endtask
endmodule

`default_nettype wire

// [bench/testbench.sv]
// self-checking testbench for the transmit parallel character capture port
`timescale 1ns/1ns
`default_nettype none

module testbench;
    // ============================================================
    // clock, reset, configuration and wiring
    logic                clk = 1'b0;
    logic                rstn = 1'b0;
    logic                ce = 1'b1;
    logic                fifo_bypass_n = 1'b1;
    logic                external_fifo_mode = 1'b0;
    logic                char_width_select = 1'b1;
    logic                encoder_bypass_n = 1'b1;
    wire logic           fclk, rclk, cs_n, we, sel;
    wire logic [7:0]     low;
    wire logic [1:0]     sh, cl;
    txc_pkg::txc_char_t  tx_char_q;
    logic                is_cmd, precoded, strobe;
    int                  failures = 0;
    int                  samples_checked = 0;
    int                  n_wr = 0;
    logic [13:0]         last = 14'h0000;

    always #10 clk = ~clk;

    txc_host_model u_host (.clk(clk), .tx_fifo_clock(fclk), .ref_clock_in(rclk),
        .tx_chip_select_n(cs_n), .tx_write_enable(we), .tx_cmd_data_select(sel),
        .tx_char_low_in(low), .tx_shared_upper_in(sh), .tx_command_low_in(cl));

    txc_capture u_dut (.clk(clk), .rstn(rstn), .ce(ce), .tx_fifo_clock(fclk),
        .ref_clock_in(rclk), .fifo_bypass_n(fifo_bypass_n),
        .external_fifo_mode(external_fifo_mode), .tx_chip_select_n(cs_n),
        .tx_write_enable(we), .char_width_select(char_width_select),
        .encoder_bypass_n(encoder_bypass_n), .tx_cmd_data_select(sel),
        .tx_char_low_in(low), .tx_shared_upper_in(sh), .tx_command_low_in(cl),
        .tx_char_q(tx_char_q), .tx_char_is_cmd_q(is_cmd),
        .tx_char_precoded_q(precoded), .tx_write_strobe_q(strobe));

    // each strobe counts one write and keeps {command, pre-encoded, character}
    always @(posedge clk)
        if (strobe === 1'b1)
        begin
            n_wr <= n_wr + 1;
            last <= {is_cmd, precoded, tx_char_q};
        end

    // ============================================================
    // shared tasks
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            failures++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic cfg(input logic c, input logic fb, input logic m, input logic w,
                       input logic e);
        @(posedge clk);
        #1;
        {ce, fifo_bypass_n, external_fifo_mode, char_width_select, encoder_bypass_n} =
            {c, fb, m, w, e};
    endtask

    task automatic xfer(input logic use_ref, input logic cs_ok, input logic s,
                        input logic [7:0] lo, input logic [1:0] up, input logic [1:0] cm,
                        input logic wr, input logic [13:0] exp);
        int base;
        base = n_wr;
        u_host.send(external_fifo_mode, use_ref, cs_ok, s, lo, up, cm);
        repeat (4) @(posedge clk);
        check(16'(n_wr - base), {15'h0000, wr});
        if (wr)
            check({2'h0, last}, {2'h0, exp});
    endtask

    task automatic report_and_stop;
        if (failures == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // ============================================================
    // scenarios
    task automatic t_encoded;
        cfg(1'b1, 1'b1, 1'b0, 1'b1, 1'b1);
        xfer(1'b0, 1'b1, 1'b0, 8'hA5, 2'h3, 2'h3, 1'b1, 14'h00A5);
        xfer(1'b0, 1'b1, 1'b1, 8'hFF, 2'h1, 2'h2, 1'b1, 14'h200A);
        cfg(1'b1, 1'b1, 1'b0, 1'b0, 1'b1);
        xfer(1'b0, 1'b1, 1'b0, 8'h3C, 2'h2, 2'h3, 1'b1, 14'h023C);
        xfer(1'b0, 1'b1, 1'b1, 8'hFF, 2'h3, 2'h1, 1'b1, 14'h2001);
    endtask

    task automatic t_bypass;
        cfg(1'b1, 1'b1, 1'b0, 1'b1, 1'b0);
        xfer(1'b0, 1'b1, 1'b1, 8'h5A, 2'h1, 2'h3, 1'b1, 14'h115A);
        cfg(1'b1, 1'b0, 1'b1, 1'b0, 1'b0);
        xfer(1'b1, 1'b1, 1'b1, 8'hC3, 2'h2, 2'h2, 1'b1, 14'h1AC3);
    endtask

    task automatic t_ext_fifo;
        cfg(1'b1, 1'b1, 1'b1, 1'b1, 1'b1);
        xfer(1'b0, 1'b1, 1'b0, 8'h77, 2'h0, 2'h0, 1'b1, 14'h0077);
    endtask

    task automatic t_refused;
        cfg(1'b1, 1'b1, 1'b0, 1'b1, 1'b1);
        xfer(1'b0, 1'b0, 1'b0, 8'h11, 2'h0, 2'h0, 1'b0, 14'h0000);
        xfer(1'b1, 1'b1, 1'b0, 8'h22, 2'h0, 2'h0, 1'b0, 14'h0000);
        cfg(1'b0, 1'b1, 1'b0, 1'b1, 1'b1);
        xfer(1'b0, 1'b1, 1'b0, 8'h33, 2'h0, 2'h0, 1'b0, 14'h0000);
    endtask

    // ============================================================
    // main sequence and watchdog
    initial
    begin
        repeat (12) @(posedge clk);
        #1;
        rstn = 1'b1;
        t_encoded();
        t_bypass();
        t_ext_fifo();
        t_refused();
        report_and_stop();
    end

    initial
    begin
        #(20 * 2000);
        failures++;
        report_and_stop();
    end
endmodule

`default_nettype wire
